/* rtl/exc_unit.sv */
`include "exc_map.svh"
`default_nettype none
module exc_unit
    import exc_pkg::*;
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic int_n_in,
    input wire logic nmi_in,
    input wire logic trap_in,
    input wire logic [7:0] trap_vec_in,
    input wire logic boundary_in,
    input wire logic ret_trap_in,
    input wire logic ret_int_in,
    input wire logic [15:0] ret_bytes_in,
    input wire logic set_configuration_instr_in,
    input wire logic cfg_vec_in,
    input wire logic wr_en_in,
    input wire logic [2:0] wr_sel_in,
    input wire logic [31:0] wr_data_in,
    input wire logic bus_done_in,
    input wire logic [31:0] bus_rdata_in,
    output logic bus_req_out,
    output logic bus_write_out,
    output logic [31:0] bus_addr_out,
    output logic [3:0] bus_status_out,
    output logic [1:0] bus_size_out,
    output logic [31:0] bus_wdata_out,
    output logic busy_out,
    output logic [31:0] pc_out,
    output logic [15:0] psw_out,
    output logic [15:0] mod_out,
    output logic [31:0] sb_out,
    output logic [31:0] sp_out,
    output logic [31:0] isp_out,
    output logic [31:0] dispatch_table_base_out,
    output logic cfg_vec_out,
    output logic [7:0] vec_out
);
    exc_state_t state_ff, nxt_state;
    exc_src_t src_ff;
    logic int_s1_ff, int_s2_ff, int_s3_ff, int_lvl_ff;
    logic nmi_pend_ff, return_from_maskable_ff, cfg_vec_ff;
    logic bus_req_ff, bus_write_ff, busy_ff;
    logic [15:0] psw_ff, psw_tmp_ff, mod_ff, ret_bytes_ff;
    logic [31:0] pc_ff, sb_ff, sp_ff, isp_ff, dispatch_table_base_ff;
    logic [31:0] caddr_ff, desc_ff, bus_addr_ff, bus_wdata_ff;
    logic [7:0] vec_ff;
    logic [3:0] bus_status_ff;
    logic [1:0] bus_size_ff;
    logic idle, int_go, trap_go, nmi_go, nxt_write;
    logic [31:0] nxt_addr, nxt_wdata;
    logic [3:0] nxt_status;
    logic [1:0] nxt_size;
    logic [7:0] casc_byte;

    // cascade table entry: base plus sign-extended index times four
    function automatic logic [31:0] casc_entry(
        input logic [31:0] base,
        input logic [7:0] idx
    );
        casc_entry = base + {{22{idx[7]}}, idx, 2'b00};
    endfunction : casc_entry

    function automatic logic is_bus(input exc_state_t st);
        is_bus = !(st == EXC_IDLE || st == EXC_ENTRY);
    endfunction : is_bus

    assign idle = (state_ff == EXC_IDLE);
    assign trap_go = idle && trap_in;
    assign nmi_go = idle && !trap_in && boundary_in && nmi_pend_ff;
    // level, not edge: a held request re-enters after every return
    assign int_go = idle && !trap_in && !nmi_pend_ff && boundary_in
        && !int_lvl_ff && psw_ff[`EXC_PSW_I];
    // cascaded controller answers in the lane picked by address bit 0
    assign casc_byte = caddr_ff[0] ? bus_rdata_in[15:8]
        : bus_rdata_in[7:0];

    // pin synchroniser; a change counts once stages two and three agree
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            int_s1_ff <= 1'b1;
            int_s2_ff <= 1'b1;
            int_s3_ff <= 1'b1;
            int_lvl_ff <= 1'b1;
        end else begin
            int_s1_ff <= int_n_in;
            int_s2_ff <= int_s1_ff;
            int_s3_ff <= int_s2_ff;
            if (int_s2_ff == int_s3_ff) begin
                int_lvl_ff <= int_s3_ff;
            end
        end
    end

    // a new nmi in the cycle it is taken stays pending
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            nmi_pend_ff <= 1'b0;
        end else if (nmi_in) begin
            nmi_pend_ff <= 1'b1;
        end else if (nmi_go) begin
            nmi_pend_ff <= 1'b0;
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            EXC_IDLE: begin
                if (trap_go || nmi_go || int_go) begin
                    nxt_state = EXC_ENTRY;
                end else if (ret_trap_in || ret_int_in) begin
                    nxt_state = EXC_POPP;
                end
            end
            EXC_ENTRY: begin
                nxt_state = (src_ff == EXC_SRC_TRAP) ? EXC_DESC
                    : EXC_ACK;
            end
            EXC_ACK: begin
                if (bus_done_in) begin
                    if (src_ff == EXC_SRC_INT && cfg_vec_ff
                        && bus_rdata_in[7]) begin
                        nxt_state = EXC_CTBL;
                    end else begin
                        nxt_state = EXC_DESC;
                    end
                end
            end
            EXC_CTBL: if (bus_done_in) nxt_state = EXC_CACK;
            EXC_CACK: if (bus_done_in) nxt_state = EXC_DESC;
            EXC_DESC: if (bus_done_in) nxt_state = EXC_PUSHM;
            EXC_PUSHM: if (bus_done_in) nxt_state = EXC_PUSHP;
            EXC_PUSHP: if (bus_done_in) nxt_state = EXC_SBRD;
            EXC_SBRD: if (bus_done_in) nxt_state = EXC_PBRD;
            EXC_PBRD: if (bus_done_in) nxt_state = EXC_IDLE;
            EXC_POPP: if (bus_done_in) nxt_state = EXC_POPM;
            EXC_POPM: if (bus_done_in) nxt_state = EXC_RSB;
            EXC_RSB: begin
                if (bus_done_in) begin
                    nxt_state = return_from_maskable_ff ? EXC_EOI : EXC_IDLE;
                end
            end
            EXC_EOI: begin
                if (bus_done_in) begin
                    nxt_state = (cfg_vec_ff && bus_rdata_in[7])
                        ? EXC_ETBL : EXC_IDLE;
                end
            end
            EXC_ETBL: if (bus_done_in) nxt_state = EXC_ECAS;
            EXC_ECAS: if (bus_done_in) nxt_state = EXC_IDLE;
            default: nxt_state = EXC_IDLE;
        endcase
    end

    // bus set-up for the state about to be entered
    always_comb begin
        nxt_addr = 32'h00000000;
        nxt_write = 1'b0;
        nxt_status = `EXC_ST_DATA;
        nxt_size = `EXC_SZ_DWORD;
        nxt_wdata = 32'h00000000;
        case (nxt_state)
            EXC_ACK: begin
                nxt_addr = (src_ff == EXC_SRC_NMI) ? `EXC_ACK_NMI
                    : `EXC_ACK_MASKABLE;
                nxt_status = `EXC_ST_ACK_MASTER;
                nxt_size = `EXC_SZ_BYTE;
            end
            EXC_CTBL, EXC_ETBL: begin
                nxt_addr = casc_entry(dispatch_table_base_ff,
                    bus_rdata_in[7:0]);
            end
            EXC_CACK: begin
                nxt_addr = bus_rdata_in;
                nxt_status = `EXC_ST_ACK_CASC;
                nxt_size = `EXC_SZ_BYTE;
            end
            EXC_DESC: nxt_addr = dispatch_table_base_ff + {22'h0, vec_src(), 2'b00};
            EXC_PUSHM: begin
                nxt_write = 1'b1;
                nxt_addr = isp_ff - 32'h00000004;
                nxt_wdata = {psw_tmp_ff, mod_ff};
            end
            // isp only moves at the done edge, so this slot is isp-8
            EXC_PUSHP: begin
                nxt_write = 1'b1;
                nxt_addr = isp_ff - 32'h00000008;
                nxt_wdata = pc_ff;
            end
            EXC_SBRD: nxt_addr = {16'h0000, desc_ff[15:0]};
            EXC_PBRD: nxt_addr = {16'h0000, desc_ff[15:0]}
                + `EXC_PROG_BASE_OFS;
            EXC_POPP: nxt_addr = isp_ff;
            EXC_POPM: nxt_addr = isp_ff + 32'h00000004;
            EXC_RSB: nxt_addr = {16'h0000, bus_rdata_in[15:0]};
            EXC_EOI: begin
                nxt_addr = `EXC_ACK_MASKABLE;
                nxt_status = `EXC_ST_EOI_MASTER;
                nxt_size = `EXC_SZ_BYTE;
            end
            EXC_ECAS: begin
                nxt_addr = bus_rdata_in;
                nxt_status = `EXC_ST_EOI_CASC;
                nxt_size = `EXC_SZ_BYTE;
            end
            default: nxt_addr = 32'h00000000;
        endcase
    end

    // vector that the descriptor read is about to use
    function automatic logic [7:0] vec_src();
        if (state_ff == EXC_ENTRY) begin
            vec_src = vec_ff;
        end else if (state_ff == EXC_CACK) begin
            vec_src = casc_byte;
        end else if (src_ff == EXC_SRC_NMI) begin
            vec_src = `EXC_NMI_VECTOR;
        end else if (!cfg_vec_ff) begin
            vec_src = 8'h00;
        end else begin
            vec_src = bus_rdata_in[7:0];
        end
    endfunction : vec_src

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_ff <= EXC_IDLE;
            busy_ff <= 1'b0;
            bus_req_ff <= 1'b0;
            bus_write_ff <= 1'b0;
            bus_addr_ff <= 32'h00000000;
            bus_status_ff <= `EXC_ST_DATA;
            bus_size_ff <= `EXC_SZ_DWORD;
            bus_wdata_ff <= 32'h00000000;
        end else begin
            state_ff <= nxt_state;
            busy_ff <= (nxt_state != EXC_IDLE);
            bus_req_ff <= is_bus(nxt_state);
            // latched on entry only: must not follow rdata while waiting
            if (nxt_state != state_ff) begin
                bus_write_ff <= nxt_write;
                bus_addr_ff <= nxt_addr;
                bus_status_ff <= nxt_status;
                bus_size_ff <= nxt_size;
                bus_wdata_ff <= nxt_wdata;
            end
        end
    end

    // entry bookkeeping: source, vector, table values
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            src_ff <= EXC_SRC_TRAP;
            return_from_maskable_ff <= 1'b0;
            vec_ff <= 8'h00;
            caddr_ff <= 32'h00000000;
            desc_ff <= 32'h00000000;
            ret_bytes_ff <= 16'h0000;
        end else begin
            if (trap_go) begin
                src_ff <= EXC_SRC_TRAP;
                vec_ff <= trap_vec_in;
            end else if (nmi_go) begin
                src_ff <= EXC_SRC_NMI;
            end else if (int_go) begin
                src_ff <= EXC_SRC_INT;
            end else if (idle && (ret_trap_in || ret_int_in)) begin
                return_from_maskable_ff <= ret_int_in && !ret_trap_in;
                // return_from_maskable never discards parameters
                ret_bytes_ff <= ret_int_in ? 16'h0000
                    : ret_bytes_in;
            end
            if (bus_done_in) begin
                case (state_ff)
                    EXC_ACK: vec_ff <= vec_src();
                    EXC_CTBL: caddr_ff <= bus_rdata_in;
                    EXC_CACK: vec_ff <= casc_byte;
                    EXC_DESC: desc_ff <= bus_rdata_in;
                    default: caddr_ff <= caddr_ff;
                endcase
            end
        end
    end

    // architectural registers; bus results outrank core writes
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            psw_ff <= `EXC_PSW_RESET;
            psw_tmp_ff <= `EXC_PSW_RESET;
            mod_ff <= 16'h0000;
            pc_ff <= 32'h00000000;
            sb_ff <= 32'h00000000;
            sp_ff <= 32'h00000000;
            isp_ff <= 32'h00000000;
            dispatch_table_base_ff <= `EXC_DISPATCH_TABLE_BASE_RESET;
        end else if (state_ff == EXC_ENTRY) begin
            psw_tmp_ff <= psw_ff;
            psw_ff[`EXC_PSW_S] <= 1'b0;
            psw_ff[`EXC_PSW_U] <= 1'b0;
            psw_ff[`EXC_PSW_T] <= 1'b0;
            psw_ff[`EXC_PSW_P] <= 1'b0;
            if (src_ff != EXC_SRC_TRAP) begin
                psw_ff[`EXC_PSW_I] <= 1'b0;
            end
        end else if (bus_done_in) begin
            case (state_ff)
                EXC_PUSHM: isp_ff <= isp_ff - 32'h00000004;
                EXC_PUSHP: isp_ff <= isp_ff - 32'h00000004;
                EXC_SBRD: begin
                    mod_ff <= desc_ff[15:0];
                    sb_ff <= bus_rdata_in;
                end
                EXC_PBRD: begin
                    pc_ff <= bus_rdata_in
                        + {16'h0000, desc_ff[31:16]};
                end
                EXC_POPP: begin
                    pc_ff <= bus_rdata_in;
                    isp_ff <= isp_ff + 32'h00000004;
                end
                EXC_POPM: begin
                    psw_ff <= bus_rdata_in[31:16];
                    mod_ff <= bus_rdata_in[15:0];
                    isp_ff <= isp_ff + 32'h00000004;
                end
                EXC_RSB: begin
                    sb_ff <= bus_rdata_in;
                    sp_ff <= sp_ff + {16'h0000, ret_bytes_ff};
                end
                default: sb_ff <= sb_ff;
            endcase
        end else if (idle && wr_en_in) begin
            case (wr_sel_in)
                `EXC_SEL_PC: pc_ff <= wr_data_in;
                `EXC_SEL_PSW: psw_ff <= wr_data_in[15:0];
                `EXC_SEL_MOD: mod_ff <= wr_data_in[15:0];
                `EXC_SEL_SB: sb_ff <= wr_data_in;
                `EXC_SEL_SP: sp_ff <= wr_data_in;
                `EXC_SEL_ISP: isp_ff <= wr_data_in;
                `EXC_SEL_DISPATCH_TABLE_BASE: dispatch_table_base_ff <= wr_data_in;
                default: pc_ff <= pc_ff;
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg_vec_ff <= 1'b0;
        end else if (set_configuration_instr_in) begin
            cfg_vec_ff <= cfg_vec_in;
        end
    end

    assign bus_req_out = bus_req_ff;
    assign bus_write_out = bus_write_ff;
    assign bus_addr_out = bus_addr_ff;
    assign bus_status_out = bus_status_ff;
    assign bus_size_out = bus_size_ff;
    assign bus_wdata_out = bus_wdata_ff;
    assign busy_out = busy_ff;
    assign pc_out = pc_ff;
    assign psw_out = psw_ff;
    assign mod_out = mod_ff;
    assign sb_out = sb_ff;
    assign sp_out = sp_ff;
    assign isp_out = isp_ff;
    assign dispatch_table_base_out = dispatch_table_base_ff;
    assign cfg_vec_out = cfg_vec_ff;
    assign vec_out = vec_ff;
endmodule : exc_unit
`default_nettype wire

/* rtl/exc_map.svh */
`ifndef EXC_MAP_SVH
`define EXC_MAP_SVH
`define EXC_ACK_MASKABLE 32'h00fffe00
`define EXC_ACK_NMI 32'h00ffff00
`define EXC_ST_ACK_MASTER 4'h4
`define EXC_ST_ACK_CASC 4'h5
`define EXC_ST_EOI_MASTER 4'h6
`define EXC_ST_EOI_CASC 4'h7
`define EXC_ST_DATA 4'ha
`define EXC_SZ_BYTE 2'h0
`define EXC_SZ_DWORD 2'h2
`define EXC_PSW_T 1
`define EXC_PSW_U 8
`define EXC_PSW_S 9
`define EXC_PSW_P 10
`define EXC_PSW_I 11
`define EXC_PSW_RESET 16'h0000
`define EXC_DISPATCH_TABLE_BASE_RESET 32'h00000000
`define EXC_NMI_VECTOR 8'h01
`define EXC_SEL_PC 3'h0
`define EXC_SEL_PSW 3'h1
`define EXC_SEL_MOD 3'h2
`define EXC_SEL_SB 3'h3
`define EXC_SEL_SP 3'h4
`define EXC_SEL_ISP 3'h5
`define EXC_SEL_DISPATCH_TABLE_BASE 3'h6
`define EXC_PROG_BASE_OFS 32'h00000008
`endif

/* rtl/exc_pkg.sv */
`default_nettype none
package exc_pkg;
    typedef enum logic [15:0] {
        EXC_IDLE = 16'h0001,
        EXC_ENTRY = 16'h0002,
        EXC_ACK = 16'h0004,
        EXC_CTBL = 16'h0008,
        EXC_CACK = 16'h0010,
        EXC_DESC = 16'h0020,
        EXC_PUSHM = 16'h0040,
        EXC_PUSHP = 16'h0080,
        EXC_SBRD = 16'h0100,
        EXC_PBRD = 16'h0200,
        EXC_POPP = 16'h0400,
        EXC_POPM = 16'h0800,
        EXC_RSB = 16'h1000,
        EXC_EOI = 16'h2000,
        EXC_ETBL = 16'h4000,
        EXC_ECAS = 16'h8000
    } exc_state_t;
    typedef enum logic [2:0] {
        EXC_SRC_TRAP = 3'h1,
        EXC_SRC_NMI = 3'h2,
        EXC_SRC_INT = 3'h4
    } exc_src_t;
endpackage : exc_pkg
`default_nettype wire

/* testbench/exc_checker.sv */
`include "exc_map.svh"
`default_nettype none
module exc_checker (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic bus_done_in,
    input wire logic [31:0] bus_rdata_in,
    input wire logic bus_req_out,
    input wire logic bus_write_out,
    input wire logic [31:0] bus_addr_out,
    input wire logic [3:0] bus_status_out,
    input wire logic [1:0] bus_size_out,
    input wire logic busy_out,
    input wire logic [15:0] psw_out,
    input wire logic cfg_vec_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!arst_n_in);

    sequence s_at(st);
        bus_req_out && bus_status_out == st;
    endsequence
    // a completed master cycle that names a cascaded controller
    sequence s_neg(st);
        bus_req_out && bus_status_out == st && bus_done_in &&
            bus_addr_out == `EXC_ACK_MASKABLE && cfg_vec_out &&
            bus_rdata_in[7];
    endsequence

    AST_ACK_CASC: assert property (s_neg(`EXC_ST_ACK_MASTER) |->
        ##[1:40] s_at(`EXC_ST_ACK_CASC))
        else $error("cascaded acknowledge missing");
    AST_EOI_CASC: assert property (s_neg(`EXC_ST_EOI_MASTER) |->
        ##[1:40] s_at(`EXC_ST_EOI_CASC))
        else $error("cascaded end of interrupt missing");
    AST_ACK_ADDR: assert property (s_at(`EXC_ST_ACK_MASTER) |->
        (bus_addr_out == `EXC_ACK_MASKABLE || bus_addr_out == `EXC_ACK_NMI)
        && bus_size_out == `EXC_SZ_BYTE && !bus_write_out)
        else $error("acknowledge address or size wrong");
    AST_ACK_PSW: assert property (s_at(`EXC_ST_ACK_MASTER) |->
        psw_out[11:8] == 4'h0)
        else $error("status word not forced before acknowledge");
    AST_HOLD: assert property (bus_req_out && !bus_done_in |=>
        $stable(bus_addr_out) && $stable(bus_status_out))
        else $error("bus request changed before done");
    AST_WR_DWORD: assert property (bus_req_out && bus_write_out |->
        bus_size_out == `EXC_SZ_DWORD && bus_status_out == `EXC_ST_DATA)
        else $error("stack push not a dword data write");
    AST_EOI_ADDR: assert property (s_at(`EXC_ST_EOI_MASTER) |->
        bus_addr_out == `EXC_ACK_MASKABLE && bus_size_out == `EXC_SZ_BYTE)
        else $error("end of interrupt address or size wrong");
    AST_BUSY: assert property (bus_req_out |-> busy_out)
        else $error("bus cycle outside a sequence");
endmodule : exc_checker

bind exc_unit exc_checker u_chk (.clk_in, .arst_n_in, .bus_done_in,
    .bus_rdata_in, .bus_req_out, .bus_write_out, .bus_addr_out,
    .bus_status_out, .bus_size_out, .busy_out, .psw_out, .cfg_vec_out);
`default_nettype wire

/* testbench/exc_pic_model.sv */
`default_nettype none
module exc_pic_model (
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic bus_req_in,
    input wire logic bus_write_in,
    input wire logic [31:0] bus_addr_in,
    input wire logic [3:0] bus_status_in,
    input wire logic [31:0] bus_wdata_in,
    output logic bus_done_out,
    output logic [31:0] bus_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [31:0]];
    logic [35:0] trc [$];
    logic [7:0] mvec = 8'h00;
    logic [7:0] cvec = 8'h00;
    int lat = 0;
    int cnt;

    function automatic logic [31:0] answer(input logic [3:0] s,
                                           input logic [31:0] a);
        case (s)
            4'h4, 4'h6: return {24'h5a5a5a, mvec};
            4'h5, 4'h7: return a[0] ? {16'h5a5a, cvec, 8'ha5}
                                    : {24'h5a5a5a, cvec};
            default: return mem.exists(a) ? mem[a] : 32'h0;
        endcase
    endfunction : answer

    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_done_out <= 1'b0;
            bus_rdata_out <= 32'h0;
            cnt <= -1;
        end else begin
            // released data lines never hold the last value
            bus_rdata_out <= ~bus_rdata_out;
            bus_done_out <= 1'b0;
            if (bus_done_out || !bus_req_in) begin
                cnt <= -1;
            end else if (cnt < lat) begin
                cnt <= cnt + 1;
            end else begin
                bus_done_out <= 1'b1;
                bus_rdata_out <= answer(bus_status_in, bus_addr_in);
                trc.push_back({bus_status_in, bus_addr_in});
                if (bus_write_in) begin
                    mem[bus_addr_in] = bus_wdata_in;
                end
            end
        end
    end
endmodule : exc_pic_model
`default_nettype wire

/* testbench/tb_top.sv */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic int_n_in = 1'b1;
    logic nmi_in = 1'b0;
    logic trap_in = 1'b0;
    logic ret_trap_in = 1'b0;
    logic ret_int_in = 1'b0;
    logic boundary_in = 1'b1;
    logic set_configuration_instr_in = 1'b0;
    logic cfg_vec_in = 1'b0;
    logic wr_en_in = 1'b0;
    logic [7:0] trap_vec_in = 8'h00;
    logic [15:0] ret_bytes_in = 16'h0010;
    logic [2:0] wr_sel_in = 3'h0;
    logic [31:0] wr_data_in = 32'h0;
    logic bus_done_in, bus_req_out, bus_write_out, busy_out, cfg_vec_out;
    logic [31:0] bus_rdata_in, bus_addr_out, bus_wdata_out, pc_out, sb_out;
    logic [31:0] sp_out, isp_out, dispatch_table_base_out;
    logic [3:0] bus_status_out;
    logic [1:0] bus_size_out;
    logic [15:0] psw_out, mod_out;
    logic [7:0] vec_out;
    logic seen;
    int bad_count = 0;
    int checks = 0;

    initial forever #2.5 clk_in = ~clk_in;

    exc_unit u_dut (.clk_in, .arst_n_in, .int_n_in, .nmi_in, .trap_in,
        .trap_vec_in, .boundary_in, .ret_trap_in, .ret_int_in,
        .ret_bytes_in, .set_configuration_instr_in, .cfg_vec_in, .wr_en_in, .wr_sel_in,
        .wr_data_in, .bus_done_in, .bus_rdata_in, .bus_req_out,
        .bus_write_out, .bus_addr_out, .bus_status_out, .bus_size_out,
        .bus_wdata_out, .busy_out, .pc_out, .psw_out, .mod_out, .sb_out,
        .sp_out, .isp_out, .dispatch_table_base_out, .cfg_vec_out, .vec_out);

    exc_pic_model pic (.clk_in, .arst_n_in, .bus_req_in(bus_req_out),
        .bus_write_in(bus_write_out), .bus_addr_in(bus_addr_out),
        .bus_status_in(bus_status_out), .bus_wdata_in(bus_wdata_out),
        .bus_done_out(bus_done_in), .bus_rdata_out(bus_rdata_in));

    task automatic final_report;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [35:0] got, exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // bounded wait for a whole sequence: busy up, then busy down
    task automatic run;
        int n;
        n = 0;
        while (busy_out !== 1'b1 && n < 80) begin
            @(negedge clk_in);
            n++;
        end
        if (busy_out !== 1'b1) begin
            bad_count++;
            final_report();
        end
        while (busy_out !== 1'b0 && n < 400) begin
            @(negedge clk_in);
            n++;
        end
        if (busy_out !== 1'b0) begin
            bad_count++;
            final_report();
        end
    endtask : run

    task automatic pulse(input int k);
        @(negedge clk_in);
        {trap_in, ret_trap_in, ret_int_in} = 3'b001 << k;
        @(negedge clk_in);
        {trap_in, ret_trap_in, ret_int_in} = 3'b000;
    endtask : pulse

    task automatic wr(input logic [2:0] s, input logic [31:0] d);
        @(negedge clk_in);
        wr_en_in = 1'b1;
        wr_sel_in = s;
        wr_data_in = d;
        @(negedge clk_in);
        wr_en_in = 1'b0;
    endtask : wr

    task automatic quiet;
        seen = 1'b0;
        repeat (20) begin
            @(negedge clk_in);
            seen |= busy_out;
        end
    endtask : quiet

    task automatic setup(input logic v);
        wr(3'h0, 32'h4000);
        wr(3'h1, 32'h0b00);
        wr(3'h2, 32'h0300);
        wr(3'h3, 32'h5555);
        wr(3'h4, 32'h3000);
        wr(3'h5, 32'h2000);
        wr(3'h6, 32'h1000);
        cfg_vec_in = v;
        set_configuration_instr_in = 1'b1;
        @(negedge clk_in);
        set_configuration_instr_in = 1'b0;
        chk("cfg", cfg_vec_out, v);
        chk("base", dispatch_table_base_out, 32'h1000);
        pic.mem[32'h1ffc] = 32'h0;
        pic.mem[32'h1ff8] = 32'h0;
        pic.trc.delete();
    endtask : setup

    task automatic ent(input logic [7:0] v, input logic [15:0] p);
        chk("pc", pc_out, 32'h7000 + v);
        chk("mod", mod_out, 16'h0600);
        chk("sb", sb_out, 32'h6666);
        chk("vec", vec_out, v);
        chk("psw", psw_out, p);
        chk("push_psw", pic.mem[32'h1ffc], 32'h0b000300);
        chk("push_pc", pic.mem[32'h1ff8], 32'h4000);
        chk("isp", isp_out, 32'h1ff8);
    endtask : ent

    task automatic back;
        chk("pc", pc_out, 32'h4000);
        chk("psw", psw_out, 16'h0b00);
        chk("mod", mod_out, 16'h0300);
        chk("sb", sb_out, 32'h5555);
        chk("isp", isp_out, 32'h2000);
    endtask : back

    // let the pin synchroniser drain before returning
    task automatic return_from_maskable;
        int_n_in = 1'b1;
        repeat (6) @(negedge clk_in);
        pic.trc.delete();
        pulse(0);
        run();
        back();
    endtask : return_from_maskable

    task automatic s_nonvec;
        setup(1'b0);
        pic.mvec = 8'h25;
        int_n_in = 1'b0;
        run();
        ent(8'h00, 16'h0000);
        chk("ack", pic.trc[0], {4'h4, 32'h00fffe00});
        return_from_maskable();
        chk("sp", sp_out, 32'h3000);
        chk("eoi", pic.trc[$], {4'h6, 32'h00fffe00});
    endtask : s_nonvec

    task automatic s_vec;
        setup(1'b1);
        pic.lat = 3;
        pic.mvec = 8'h7f;
        int_n_in = 1'b0;
        run();
        ent(8'h7f, 16'h0000);
        quiet();
        chk("masked", seen, 1'b0);
        boundary_in = 1'b0;
        pulse(0);
        run();
        back();
        quiet();
        chk("no_boundary", seen, 1'b0);
        pic.mem[32'h1ff8] = 32'h0;
        boundary_in = 1'b1;
        run();
        ent(8'h7f, 16'h0000);
        return_from_maskable();
        pic.lat = 0;
    endtask : s_vec

    task automatic s_casc;
        setup(1'b1);
        pic.mvec = 8'hf3;
        pic.cvec = 8'hc8;
        int_n_in = 1'b0;
        run();
        ent(8'hc8, 16'h0000);
        chk("tbl", pic.trc[1], {4'ha, 32'h00000fcc});
        chk("cack", pic.trc[2], {4'h5, 32'h00abc001});
        return_from_maskable();
        chk("etbl", pic.trc[$-1], {4'ha, 32'h00000fcc});
        chk("ecas", pic.trc[$], {4'h7, 32'h00abc001});
    endtask : s_casc

    task automatic s_trap;
        setup(1'b0);
        trap_vec_in = 8'h05;
        pulse(2);
        run();
        ent(8'h05, 16'h0800);
        pulse(1);
        run();
        back();
        chk("sp", sp_out, 32'h3010);
        setup(1'b0);
        @(negedge clk_in);
        nmi_in = 1'b1;
        @(negedge clk_in);
        nmi_in = 1'b0;
        run();
        ent(8'h01, 16'h0000);
        chk("nmi_ack", pic.trc[0], {4'h4, 32'h00ffff00});
        pulse(1);
        run();
        back();
        chk("sp", sp_out, 32'h3010);
    endtask : s_trap

    initial begin
        for (int v = 0; v < 256; v++) begin
            pic.mem[32'h1000 + 32'(4 * v)] = {v[15:0], 16'h0600};
        end
        pic.mem[32'h600] = 32'h6666;
        pic.mem[32'h608] = 32'h7000;
        pic.mem[32'h300] = 32'h5555;
        pic.mem[32'hfcc] = 32'h00abc001;
        repeat (4) @(negedge clk_in);
        arst_n_in = 1'b1;
        s_nonvec();
        s_vec();
        s_casc();
        s_trap();
        final_report();
    end
endmodule : tb_top
`default_nettype wire
